// ### verilog/iod_defs.vh
`ifndef IOD_DEFS_VH
`define IOD_DEFS_VH

// byte addresses of the output words
`define IOD_ADDR_RATE_X_FRACTION 8'h04
`define IOD_ADDR_RATE_X_MAIN 8'h06
`define IOD_ADDR_RATE_Y_FRACTION 8'h08
`define IOD_ADDR_RATE_Y_MAIN 8'h0A
`define IOD_ADDR_RATE_Z_FRACTION 8'h0C
`define IOD_ADDR_RATE_Z_MAIN 8'h0E
`define IOD_ADDR_ACCEL_X_FRACTION 8'h10
`define IOD_ADDR_ACCEL_X_MAIN 8'h12

// value read before the first sample and at unmapped addresses
`define IOD_READ_IDLE 16'h0000
// rate range selects
`define IOD_RANGE_125 2'h0
`define IOD_RANGE_500 2'h1
`define IOD_RANGE_2000 2'h2
// high word full scale
`define IOD_RATE_FS_POS 16'h4E20
`define IOD_RATE_FS_NEG 16'hB1E0
`define IOD_ACCEL_FS_POS 16'h7D00
`define IOD_ACCEL_FS_NEG 16'h8300
// channel index of the results
`define IOD_CH_RATE_X 2'h0
`define IOD_CH_RATE_Y 2'h1
`define IOD_CH_RATE_Z 2'h2
`define IOD_CH_ACCEL_X 2'h3

`endif

// ### verilog/iod_clamp.v
`timescale 1ns/1ps
`include "iod_defs.vh"

module iod_clamp (
    // raw 32-bit twos-complement sample
    input wire [31:0] raw_i,
    // full scale of the high word
    input wire [15:0] fs_pos_i,
    input wire [15:0] fs_neg_i,
    // limited sample
    output reg [31:0] val_o
);
    wire signed [31:0] raw_s;
    wire signed [31:0] pos_s;
    wire signed [31:0] neg_s;
    assign raw_s = raw_i;
    assign pos_s = {fs_pos_i, 16'h0000};
    assign neg_s = {fs_neg_i, 16'h0000};

    // hold the result inside full scale
    always @* begin
        if (raw_s > pos_s) begin
            val_o = pos_s;
        end else if (raw_s < neg_s) begin
            val_o = neg_s;
        end else begin
            val_o = raw_i;
        end
    end
endmodule

// ### verilog/iod_word_mux.v
`timescale 1ns/1ps
`include "iod_defs.vh"

module iod_word_mux (
    // register byte address
    input wire [7:0] addr_i,
    // stored results
    input wire [127:0] res_i,
    // selected word and hit
    output reg [15:0] word_o,
    output reg hit_o
);
    always @* begin
        hit_o = 1'b1;
        case (addr_i)
            `IOD_ADDR_RATE_X_FRACTION: word_o = res_i[15:0];
            `IOD_ADDR_RATE_X_MAIN: word_o = res_i[31:16];
            `IOD_ADDR_RATE_Y_FRACTION: word_o = res_i[47:32];
            `IOD_ADDR_RATE_Y_MAIN: word_o = res_i[63:48];
            `IOD_ADDR_RATE_Z_FRACTION: word_o = res_i[79:64];
            `IOD_ADDR_RATE_Z_MAIN: word_o = res_i[95:80];
            `IOD_ADDR_ACCEL_X_FRACTION: word_o = res_i[111:96];
            `IOD_ADDR_ACCEL_X_MAIN: word_o = res_i[127:112];
            default: begin
                word_o = `IOD_READ_IDLE;
                hit_o = 1'b0;
            end
        endcase
    end
endmodule

// ### verilog/iod_output_regs.v
`timescale 1ns/1ps
`include "iod_defs.vh"

// How it works
// - rate x low word sits at 0x04 and its high word at 0x06.
// - rate high words are twos complement, zero rate reads 0x0000.
// - rate y low word sits at 0x08 and its high word at 0x0A.
// - rate z low word sits at 0x0C and its high word at 0x0E.
// - all result words are read only and read 0x0000 after reset until their channel loads.
// - rate high word full scale reads 0x4E20 and 0xB1E0.
// - rate 32-bit full scale reads 0x4E200000 and 0xB1E00000.
// - accel low and high words join into one 32-bit twos complement.
// - accel high word full scale reads 0x7D00 and 0x8300.
// - accel 32-bit full scale reads 0x7D000000 and 0x83000000.
// - accel x low word sits at 0x10.
// - accel x high word sits at 0x12, zero reads 0x0000.
// - the rate range select only tags the scale of one count.
// - rate low and high words join into one 32-bit twos complement.
module iod_output_regs #(
    parameter [1:0] RANGE_SEL = `IOD_RANGE_2000
) (
    // clock and reset
    input wire sys_clk_i,
    input wire resetn_i,
    // sample load from the signal path
    input wire smp_valid_i,
    input wire [1:0] smp_ch_i,
    input wire [31:0] smp_data_i,
    // register read port
    input wire rd_en_i,
    input wire [7:0] rd_addr_i,
    // read answer
    output reg [15:0] rd_data_o,
    output reg rd_valid_o,
    output reg rd_err_o,
    // range of the rate scale
    output reg [1:0] range_o
);
    // sizes of the result store
    localparam CH_NUM = 4;
    localparam SMP_W = 32;
    localparam WORD_W = 16;
    localparam FLAT_W = CH_NUM * SMP_W;

    // no write strobe on any channel
    localparam [3:0] MASK_NONE = 4'h0;

    // one result per channel in plain flip-flops, no reset on purpose
    reg [SMP_W-1:0] res_q [0:CH_NUM-1];

    // channels that hold a sample since reset
    reg [CH_NUM-1:0] loaded_q;
    reg [CH_NUM-1:0] loaded_d;

    // sample path
    wire rate_ch_w;
    wire [WORD_W-1:0] fs_pos_w;
    wire [WORD_W-1:0] fs_neg_w;
    wire [SMP_W-1:0] lim_w;
    wire [CH_NUM-1:0] load_w;

    // read path
    wire [FLAT_W-1:0] res_flat_w;
    wire [WORD_W-1:0] word_w;
    wire hit_w;

    // next values of the answer registers
    reg [WORD_W-1:0] rd_data_d;
    reg rd_valid_d;
    reg rd_err_d;
    reg [1:0] range_d;

    // rate channels take the rate full scale, the rest the accel one
    function ch_is_rate;
        input [1:0] ch;
        begin
            case (ch)
                `IOD_CH_RATE_X: begin
                    ch_is_rate = 1'b1;
                end
                `IOD_CH_RATE_Y: begin
                    ch_is_rate = 1'b1;
                end
                `IOD_CH_RATE_Z: begin
                    ch_is_rate = 1'b1;
                end
                `IOD_CH_ACCEL_X: begin
                    ch_is_rate = 1'b0;
                end
                default: begin
                    ch_is_rate = 1'b0;
                end
            endcase
        end
    endfunction

    // one-hot write strobe of a channel index
    function [3:0] ch_mask;
        input [1:0] ch;
        begin
            case (ch)
                `IOD_CH_RATE_X: begin
                    ch_mask = 4'h1;
                end
                `IOD_CH_RATE_Y: begin
                    ch_mask = 4'h2;
                end
                `IOD_CH_RATE_Z: begin
                    ch_mask = 4'h4;
                end
                `IOD_CH_ACCEL_X: begin
                    ch_mask = 4'h8;
                end
                default: begin
                    ch_mask = MASK_NONE;
                end
            endcase
        end
    endfunction

    // positive full scale of the high word
    function [15:0] fs_pos_of;
        input is_rate;
        begin
            if (is_rate) begin
                fs_pos_of = `IOD_RATE_FS_POS;
            end else begin
                fs_pos_of = `IOD_ACCEL_FS_POS;
            end
        end
    endfunction

    // negative full scale of the high word
    function [15:0] fs_neg_of;
        input is_rate;
        begin
            if (is_rate) begin
                fs_neg_of = `IOD_RATE_FS_NEG;
            end else begin
                fs_neg_of = `IOD_ACCEL_FS_NEG;
            end
        end
    endfunction

    // a word of a channel that never loaded reads as idle
    function [15:0] shown_word;
        input loaded;
        input [15:0] w;
        begin
            if (loaded) begin
                shown_word = w;
            end else begin
                shown_word = `IOD_READ_IDLE;
            end
        end
    endfunction

    // an unknown range select reports the widest range
    function [1:0] range_code;
        input [1:0] sel;
        begin
            case (sel)
                `IOD_RANGE_125: begin
                    range_code = `IOD_RANGE_125;
                end
                `IOD_RANGE_500: begin
                    range_code = `IOD_RANGE_500;
                end
                `IOD_RANGE_2000: begin
                    range_code = `IOD_RANGE_2000;
                end
                default: begin
                    range_code = `IOD_RANGE_2000;
                end
            endcase
        end
    endfunction

    // sample side

    // kind of the incoming sample
    assign rate_ch_w = ch_is_rate(smp_ch_i);

    // full scale follows the kind
    assign fs_pos_w = fs_pos_of(rate_ch_w);
    assign fs_neg_w = fs_neg_of(rate_ch_w);

    // write strobe of each channel
    assign load_w = smp_valid_i ? ch_mask(smp_ch_i) : MASK_NONE;

    // saturate the sample to its full scale
    iod_clamp u_clamp (
        .raw_i(smp_data_i),
        .fs_pos_i(fs_pos_w),
        .fs_neg_i(fs_neg_w),
        .val_o(lim_w)
    );

    // both halves of a result load in one write
    always @(posedge sys_clk_i) begin
        if (smp_valid_i) begin
            res_q[smp_ch_i] <= lim_w;
        end
    end

    // a channel counts as loaded from its first sample on
    always @* begin
        loaded_d = loaded_q | load_w;
    end

    // of the result store only the loaded flags are reset, the results are not
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            loaded_q <= {CH_NUM{1'b0}};
        end else begin
            loaded_q <= loaded_d;
        end
    end

    // read side

    // flat view of the store, low word in the lower half
    genvar g;
    generate
        for (g = 0; g < CH_NUM; g = g + 1) begin : g_flat
            wire [WORD_W-1:0] lo_w;
            wire [WORD_W-1:0] hi_w;
            assign lo_w =
                shown_word(loaded_q[g], res_q[g][WORD_W-1:0]);
            assign hi_w =
                shown_word(loaded_q[g], res_q[g][SMP_W-1:WORD_W]);
            assign res_flat_w[SMP_W*g+SMP_W-1:SMP_W*g] = {hi_w, lo_w};
        end
    endgenerate

    // address decode: halves at even byte addresses
    iod_word_mux u_mux (
        .addr_i(rd_addr_i),
        .res_i(res_flat_w),
        .word_o(word_w),
        .hit_o(hit_w)
    );

    // an answer follows every request by one cycle
    always @* begin
        rd_valid_d = rd_en_i;
    end

    // read word is taken on a request and held until the next one
    always @* begin
        rd_data_d = rd_data_o;
        if (rd_en_i) begin
            rd_data_d = word_w;
        end
    end

    // unmapped or odd addresses are refused
    always @* begin
        rd_err_d = rd_err_o;
        if (rd_en_i) begin
            rd_err_d = ~hit_w;
        end
    end

    // scale of one rate count
    always @* begin
        range_d = range_code(RANGE_SEL);
    end

    // answer valid flag
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_valid_d;
        end
    end

    // answer word, no write path exists
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= `IOD_READ_IDLE;
        end else begin
            rd_data_o <= rd_data_d;
        end
    end

    // answer refusal flag
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_err_o <= 1'b0;
        end else begin
            rd_err_o <= rd_err_d;
        end
    end

    // range tag
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            range_o <= `IOD_RANGE_125;
        end else begin
            range_o <= range_d;
        end
    end
endmodule

// ### test/iod_output_regs_properties.sv
`timescale 1ns/1ps
module iod_chk #(parameter [1:0] RANGE_SEL = 2'h2) (
    // watched ports
    input wire sys_clk_i,
    input wire resetn_i,
    input wire smp_valid_i,
    input wire [1:0] smp_ch_i,
    input wire [31:0] smp_data_i,
    input wire rd_en_i,
    input wire [7:0] rd_addr_i,
    input wire [15:0] rd_data_o,
    input wire rd_valid_o,
    input wire rd_err_o,
    input wire [1:0] range_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    wire hit = !rd_addr_i[0] && rd_addr_i >= 8'h04 && rd_addr_i <= 8'h12;
    a_read_latency: assert property (rd_en_i |=> rd_valid_o)
        else $error("read not answered");
    a_valid_cause: assert property (rd_valid_o |-> $past(rd_en_i))
        else $error("answer without read");
    a_map_hit: assert property (rd_en_i && hit |=> !rd_err_o)
        else $error("mapped read refused");
    a_unmapped_zero: assert property (rd_en_i && !hit |=>
        rd_err_o && rd_data_o == 16'h0000) else $error("bad unmapped read");
    a_answer_holds: assert property (!rd_en_i |=>
        $stable(rd_data_o) && $stable(rd_err_o)) else $error("answer moved");
    a_range_tag: assert property ($past(resetn_i) |->
        range_o == RANGE_SEL) else $error("range wrong");
    a_zero_rate: assert property (smp_valid_i && smp_ch_i == 2'h0 &&
        smp_data_i == 32'h00000000 ##1 rd_en_i && rd_addr_i == 8'h06
        |=> rd_data_o == 16'h0000) else $error("zero rate wrong");
    a_rate_fs: assert property (smp_valid_i && smp_ch_i == 2'h1 &&
        smp_data_i == 32'h7FFFFFFF ##1 rd_en_i && rd_addr_i == 8'h0A
        |=> rd_data_o == 16'h4E20) else $error("rate full scale wrong");
    c_err: cover property (rd_valid_o && rd_err_o);
    c_ok: cover property (rd_valid_o && !rd_err_o);
    c_sample: cover property (smp_valid_i ##1 rd_en_i);
endmodule

// ### test/iod_host.sv
`timescale 1ns/1ps
module iod_host (
    // read port
    input wire sys_clk_i,
    output reg rd_en_o,
    output reg [7:0] rd_addr_o,
    input wire [15:0] rd_data_i,
    input wire rd_valid_i,
    input wire rd_err_i
);
    initial begin
        rd_en_o = 1'b0;
        rd_addr_o = 8'h00;
    end
    // entered at a falling edge, answer taken at the next falling edge
    task rd(input [7:0] a, output [15:0] d, output e, output v);
        begin
            rd_en_o = 1'b1;
            rd_addr_o = a;
            @(negedge sys_clk_i);
            d = rd_data_i;
            e = rd_err_i;
            v = rd_valid_i;
            rd_en_o = 1'b0;
            rd_addr_o = ~a;
            @(negedge sys_clk_i);
        end
    endtask
endmodule

// ### test/inertial_output_data_regs_tb_top.sv
`timescale 1ns/1ps
module inertial_output_data_regs_tb_top;
    reg sys_clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg smp_valid_i = 1'b0;
    reg [1:0] smp_ch_i = 2'h0;
    reg [31:0] smp_data_i = 32'h00000000;
    wire rd_en_i, rd_valid_o, rd_err_o;
    wire [7:0] rd_addr_i;
    wire [15:0] rd_data_o;
    wire [1:0] range_o;
    integer error_cnt = 0;
    integer checks_done = 0;
    iod_output_regs #(.RANGE_SEL(2'h1)) DUT (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .smp_valid_i(smp_valid_i), .smp_ch_i(smp_ch_i),
        .smp_data_i(smp_data_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .rd_err_o(rd_err_o), .range_o(range_o));
    iod_host u_host (.sys_clk_i(sys_clk_i), .rd_en_o(rd_en_i),
        .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o),
        .rd_valid_i(rd_valid_o), .rd_err_i(rd_err_o));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task chk(input string n, input logic [33:0] s, input logic [33:0] e);
        begin
            checks_done = checks_done + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %s exp %h got %h", n, e, s);
            end
        end
    endtask
    // load one sample, read high word next cycle, then low word
    task rw(input [1:0] ch, input [31:0] din, input [31:0] exp);
        reg [15:0] hi, lo;
        reg e1, e2, v;
        begin
            smp_valid_i = 1'b1;
            smp_ch_i = ch;
            smp_data_i = din;
            @(negedge sys_clk_i);
            smp_valid_i = 1'b0;
            smp_data_i = ~din;
            u_host.rd(8'h06 + {ch, 2'h0}, hi, e1, v);
            chk("valid", v, 1'b1);
            u_host.rd(8'h04 + {ch, 2'h0}, lo, e2, v);
            chk("pair", {e1, e2, hi, lo}, {2'b00, exp});
        end
    endtask
    task t_words;
        begin
            rw(2'h0, 32'h00010002, 32'h00010002);
            rw(2'h1, 32'hFFFFFFFF, 32'hFFFFFFFF);
            rw(2'h2, 32'h12345678, 32'h12345678);
            rw(2'h3, 32'hFF00ABCD, 32'hFF00ABCD);
            rw(2'h3, 32'h00000000, 32'h00000000);
            rw(2'h0, 32'h00000000, 32'h00000000);
            $display("t_words done");
        end
    endtask
    task t_full;
        begin
            rw(2'h0, 32'h4E200000, 32'h4E200000);
            rw(2'h1, 32'h7FFFFFFF, 32'h4E200000);
            rw(2'h2, 32'h80000000, 32'hB1E00000);
            rw(2'h3, 32'h7FFFFFFF, 32'h7D000000);
            rw(2'h3, 32'h80000000, 32'h83000000);
            $display("t_full done");
        end
    endtask
    task t_unmapped;
        reg [15:0] d;
        reg e, v;
        begin
            u_host.rd(8'h05, d, e, v);
            chk("odd", {v, e, d}, {2'b11, 16'h0000});
            u_host.rd(8'h14, d, e, v);
            chk("beyond", {v, e, d}, {2'b11, 16'h0000});
            chk("range", range_o, 2'h1);
            $display("t_unmapped done");
        end
    endtask
    // reset in mid-run clears the answer and forgets the accel x sample
    task t_reset;
        reg [15:0] d;
        reg e, v;
        begin
            resetn_i = 1'b0;
            @(negedge sys_clk_i);
            chk("reset", {rd_valid_o, rd_err_o, rd_data_o, range_o},
                20'h00000);
            resetn_i = 1'b1;
            u_host.rd(8'h12, d, e, v);
            chk("cleared", {v, e, d}, {2'b10, 16'h0000});
            chk("range back", range_o, 2'h1);
            $display("t_reset done");
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        @(negedge sys_clk_i);
        t_words;
        t_full;
        t_unmapped;
        t_reset;
        finish_test;
    end
    initial begin
        #20000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
endmodule
bind iod_output_regs iod_chk #(.RANGE_SEL(RANGE_SEL)) u_chk (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .smp_valid_i(smp_valid_i),
    .smp_ch_i(smp_ch_i), .smp_data_i(smp_data_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .rd_err_o(rd_err_o), .range_o(range_o));
